/* hw/amsom_top.sv */
// control and output routing of a dual-channel 12-bit converter
// assumes core results on clk_sys, control pins and sample clock asynchronous
`timescale 1ns/1ps
module amsom_top (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // control pins and sample clock, asynchronous
  input  wire logic                 extended_ctrl_enable_n,
  input  wire logic                 interleave_pin,
  input  wire logic                 single_bus_select,
  input  wire logic                 double_rate_phase_select,
  input  wire logic                 pattern_output_select,
  input  wire logic                 powerdown_i_chan,
  input  wire logic                 powerdown_q_chan,
  input  wire logic                 sample_clk,
  // core results on clk_sys
  input  wire logic signed [13:0]   core_i,
  input  wire logic signed [13:0]   core_q,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // output buses
  output amsom_pkg::amsom_chan_t    chan_i_out,
  output amsom_pkg::amsom_chan_t    chan_q_out
);
  // ==================================================================
  // pin synchronisers
  logic [7:0] pin_raw;   // gathered pins
  logic [7:0] s1_reg;    // first stage, read only by s2
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;
  logic [7:0] flt_reg;   // accepted pin levels
  logic [7:0] flt_next;
  logic [7:0] agree;
  assign pin_raw = {sample_clk, powerdown_q_chan, powerdown_i_chan, pattern_output_select,
                    double_rate_phase_select, single_bus_select, interleave_pin,
                    extended_ctrl_enable_n};
  assign agree    = ~(s2_reg ^ s3_reg);
  assign flt_next = (agree & s3_reg) | (~agree & flt_reg);
  // three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg  <= amsom_pkg::PIN_RST;
      s2_reg  <= amsom_pkg::PIN_RST;
      s3_reg  <= amsom_pkg::PIN_RST;
      flt_reg <= amsom_pkg::PIN_RST;
    end else begin
      s1_reg  <= pin_raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= flt_next;
    end
  end
  // sample clock edges, one cycle pulses
  logic lnk_rise;
  logic lnk_fall;
  assign lnk_rise = flt_next[amsom_pkg::PIN_LNK] & ~flt_reg[amsom_pkg::PIN_LNK];
  assign lnk_fall = ~flt_next[amsom_pkg::PIN_LNK] & flt_reg[amsom_pkg::PIN_LNK];
  // ==================================================================
  // register file
  logic [15:0] regs_q [16];   // serial-mode registers
  logic        pin_mode;      // pins own the configuration
  logic [3:0]  idx;
  logic        mapped;
  logic        wr_take;
  assign pin_mode = flt_reg[amsom_pkg::PIN_XCTL];
  assign idx      = paddr[5:2];
  assign mapped   = (paddr[7:6] == 2'b00);
  assign wr_take  = psel & penable & pready & pwrite & mapped & ~pin_mode;
  function automatic logic [15:0] reg_default(input int k);
    if (k == 1 || k == 3) begin
      return amsom_pkg::GAIN_RST;
    end else if (k == 0) begin
      return amsom_pkg::CFG_RST;
    end
    return amsom_pkg::OFS_RST;
  endfunction : reg_default
  // sixteen words, pin mode forces them back to defaults
  for (genvar k = 0; k < amsom_pkg::REG_N; k++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        regs_q[k] <= reg_default(k);
      end else if (pin_mode) begin
        regs_q[k] <= reg_default(k);
      end else if (wr_take && idx == 4'(k) && idx != amsom_pkg::REG_STAT) begin
        regs_q[k] <= pwdata[15:0];
      end
    end
  end
  // ==================================================================
  // effective configuration
  amsom_pkg::amsom_cfg_t cfg;
  logic [15:0] creg;
  assign creg      = regs_q[amsom_pkg::REG_CFG];
  assign cfg.il    = pin_mode ? flt_reg[amsom_pkg::PIN_IL] : creg[amsom_pkg::CFG_IL_BIT];
  assign cfg.qsel  = ~pin_mode & creg[amsom_pkg::CFG_QSEL_BIT];
  assign cfg.both  = ~pin_mode & creg[amsom_pkg::CFG_BOTH_BIT];
  assign cfg.single = flt_reg[amsom_pkg::PIN_ONE];
  assign cfg.ph90  = pin_mode ? flt_reg[amsom_pkg::PIN_PH] : creg[amsom_pkg::CFG_PHASE_BIT];
  assign cfg.pat   = flt_reg[amsom_pkg::PIN_PAT];
  assign cfg.pd_i  = flt_reg[amsom_pkg::PIN_DOWN_I] | (~pin_mode & creg[amsom_pkg::CFG_DOWN_I_BIT]);
  assign cfg.pd_q  = flt_reg[amsom_pkg::PIN_DOWN_Q] | (~pin_mode & creg[amsom_pkg::CFG_DOWN_Q_BIT]);
  // ==================================================================
  // apb answer, zero wait states
  amsom_pkg::amsom_chan_t ch_reg [2];
  logic [15:0] rd_val;
  assign rd_val = (idx == amsom_pkg::REG_STAT) ? {6'h00, ch_reg[1].over, ch_reg[0].over, cfg} : regs_q[idx];
  // read data is latched in the setup cycle so it stands from a flop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel && !penable && mapped && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end
  // ==================================================================
  // half sample period measure, used for the midway clock
  logic [7:0] hcnt_reg;
  logic [7:0] half_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hcnt_reg <= 8'h00;
      half_reg <= amsom_pkg::LINK_HALF_CYC;
    end else if (lnk_rise || lnk_fall) begin
      hcnt_reg <= 8'h00;
      half_reg <= hcnt_reg + 8'h01;
    end else if (hcnt_reg != 8'hff) begin
      hcnt_reg <= hcnt_reg + 8'h01;
    end
  end
  // ==================================================================
  // saturation to offset binary, flag in bit 12
  function automatic logic [12:0] sat_code(input logic signed [16:0] v);
    if (v < amsom_pkg::FS_NEG) begin
      return {1'b1, amsom_pkg::ALL_ZERO};
    end else if (v > amsom_pkg::FS_POS) begin
      return {1'b1, amsom_pkg::ALL_ONE};
    end
    return {1'b0, v[11:0] ^ amsom_pkg::MID_FLIP};
  endfunction : sat_code
  // ==================================================================
  // converter events and input routing
  logic [1:0]        conv_ev;
  logic signed [13:0] src [2];
  assign conv_ev[0] = lnk_rise;
  assign conv_ev[1] = cfg.il ? lnk_fall : lnk_rise;
  // one input feeds both converters when interleaved, unless both is set; then i feeds the first and q the second
  assign src[0] = (cfg.il && cfg.qsel && !cfg.both) ? core_q : core_i;
  assign src[1] = (!cfg.il || cfg.qsel || cfg.both) ? core_q : core_i;
  logic [1:0]  pd_vec;
  logic [11:0] w_comb [2];   // word about to be written
  logic [1:0]  f_comb;
  logic [1:0]  lo_sat;
  assign pd_vec = {cfg.pd_q, cfg.pd_i};
  // ==================================================================
  // per channel datapath
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0]        gain;
    logic [15:0]        ofs;
    logic signed [29:0] prod;
    logic signed [16:0] scaled;
    logic signed [16:0] mag;
    logic signed [16:0] corr;
    logic [12:0]        sc;
    logic [11:0]        pat_reg;   // test pattern counter
    logic               bank_reg;  // next demux bus
    logic               pend_reg;  // clock toggle waiting midway
    logic [7:0]         cnt_reg;
    logic               tog;
    assign gain   = regs_q[c == 0 ? amsom_pkg::REG_GAIN_I : amsom_pkg::REG_GAIN_Q];
    assign ofs    = regs_q[c == 0 ? amsom_pkg::REG_OFS_I : amsom_pkg::REG_OFS_Q];
    assign prod   = src[c] * $signed({1'b0, gain[14:0]});
    assign scaled = 17'(prod >>> amsom_pkg::GAIN_SHIFT);
    assign mag    = $signed({5'h00, ofs[11:0]});
    assign corr   = ofs[amsom_pkg::OFS_SIGN_BIT] ? scaled - mag : scaled + mag;
    assign sc     = sat_code(corr);
    assign lo_sat[c] = sc[12] & (sc[11:0] == amsom_pkg::ALL_ZERO);
    assign w_comb[c] = cfg.pat ? pat_reg : sc[11:0];
    assign f_comb[c] = cfg.pat ? pat_reg[0] : sc[12];
    // clock toggles per word, or per pair in demux
    assign tog = conv_ev[c] & (cfg.single | bank_reg);
    // word and flag move together; the clock toggles in the same cycle unless ph90 defers it
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        ch_reg[c] <= '0;
        pat_reg   <= 12'h000;
        bank_reg  <= 1'b0;
        pend_reg  <= 1'b0;
        cnt_reg   <= 8'h00;
      end else begin
        ch_reg[c].oe <= ~pd_vec[c];
        if (conv_ev[c]) begin
          pat_reg        <= pat_reg + 12'h001;
          ch_reg[c].over <= f_comb[c];
          if (cfg.single) begin
            ch_reg[c].bus_a <= w_comb[c];
            bank_reg        <= 1'b0;
          end else if (!bank_reg) begin
            ch_reg[c].bus_a <= w_comb[c];
            bank_reg        <= 1'b1;
          end else begin
            ch_reg[c].bus_b <= w_comb[c];
            bank_reg        <= 1'b0;
          end
        end
        if (tog && !cfg.ph90) begin
          ch_reg[c].dclk <= ~ch_reg[c].dclk;
          pend_reg       <= 1'b0;
        end else if (tog) begin
          pend_reg <= 1'b1;
          cnt_reg  <= half_reg >> 1;
        end else if (pend_reg && cnt_reg == 8'h00) begin
          ch_reg[c].dclk <= ~ch_reg[c].dclk;
          pend_reg       <= 1'b0;
        end else if (pend_reg) begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end
  assign chan_i_out = ch_reg[0];
  assign chan_q_out = ch_reg[1];
  // ==================================================================
  // checks
  sequence s_lo_ev;
    conv_ev[0] && !cfg.pat && cfg.single && lo_sat[0];
  endsequence
  chk_zero_below: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_lo_ev |=> ch_reg[0].bus_a == 12'h000 && ch_reg[0].over)
    else $error("low saturation not all zeros");
  chk_ones_above: assert property (@(posedge clk_sys) disable iff (!rst_b)
    conv_ev[0] && !cfg.pat && cfg.single && f_comb[0] && !lo_sat[0] |=> ch_reg[0].bus_a == 12'hfff)
    else $error("high saturation not all ones");
  chk_flag_aligned: assert property (@(posedge clk_sys) disable iff (!rst_b)
    conv_ev[1] |=> ch_reg[1].over == $past(f_comb[1]))
    else $error("flag not aligned with word");
  chk_demux_alt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    conv_ev[0] && !cfg.single && !g_ch[0].bank_reg |=> ch_reg[0].bus_a == $past(w_comb[0])
    && g_ch[0].bank_reg && $stable(ch_reg[0].bus_b))
    else $error("demux word not on first bus");
  chk_single_bus: assert property (@(posedge clk_sys) disable iff (!rst_b)
    conv_ev[1] && cfg.single |=> ch_reg[1].bus_a == $past(w_comb[1]) && $stable(ch_reg[1].bus_b))
    else $error("single bus not updated");
  chk_pin_defaults: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_mode |=> regs_q[0] == amsom_pkg::CFG_RST && regs_q[1] == amsom_pkg::GAIN_RST)
    else $error("registers not at defaults in pin mode");
  chk_il_edges: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg.il && lnk_fall |-> conv_ev[1] && !conv_ev[0])
    else $error("interleave falling edge not taken");
  chk_pin_i_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_mode |-> src[0] == core_i && !cfg.qsel
    && src[1] == (cfg.il ? core_i : core_q))
    else $error("q input used under pin control");
  chk_pat_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
    conv_ev[0] && cfg.pat && cfg.single |=> ch_reg[0].bus_a == $past(g_ch[0].pat_reg))
    else $error("pattern not on bus");
  chk_pd_hiz: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pd_vec[0] |=> !ch_reg[0].oe)
    else $error("powered down bus still driven");
  chk_pd_hiz_q: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pd_vec[1] |=> !ch_reg[1].oe)
    else $error("powered down q bus still driven");
  // the second word of a pair must land on the other bus and leave the first alone
  chk_demux_second: assert property (@(posedge clk_sys) disable iff (!rst_b)
    conv_ev[0] && !cfg.single && g_ch[0].bank_reg |=> ch_reg[0].bus_b == $past(w_comb[0])
    && !g_ch[0].bank_reg && $stable(ch_reg[0].bus_a))
    else $error("demux word not on second bus");
  chk_zero_phase: assert property (@(posedge clk_sys) disable iff (!rst_b)
    g_ch[0].tog && !cfg.ph90 |=> ch_reg[0].dclk != $past(ch_reg[0].dclk))
    else $error("data clock not moved with word");
endmodule : amsom_top

/* shared/amsom_pkg.sv */
// constants and carrier types for the converter mode select and output mux
// assumes a 100 MHz system clock and a slower sample clock arriving as a pin
package amsom_pkg;
  // ==================================================================
  // widths
  localparam int SMP_W  = 14;  // raw signed core result, wider than a word
  localparam int WORD_W = 12;  // output word width
  localparam int REG_N  = 16;  // serial-mode register count
  localparam int REG_W  = 16;  // stored bits per register
  // ==================================================================
  // register indexes, byte address is four times the index
  localparam logic [3:0] REG_CFG    = 4'h0;
  localparam logic [3:0] REG_GAIN_I = 4'h1;
  localparam logic [3:0] REG_OFS_I  = 4'h2;
  localparam logic [3:0] REG_GAIN_Q = 4'h3;
  localparam logic [3:0] REG_OFS_Q  = 4'h4;
  localparam logic [3:0] REG_STAT   = 4'hf;
  // ==================================================================
  // configuration field positions
  localparam int CFG_PHASE_BIT  = 14;
  localparam int CFG_DOWN_I_BIT = 11;
  localparam int CFG_DOWN_Q_BIT = 10;
  localparam int CFG_IL_BIT     = 7;
  localparam int CFG_QSEL_BIT   = 6;
  localparam int CFG_BOTH_BIT   = 5;
  localparam int GAIN_SHIFT     = 14;  // gain of 1 << 14 is unity
  localparam int OFS_SIGN_BIT   = 12;  // offset is sign plus 12-bit magnitude
  // ==================================================================
  // reset values
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam logic [15:0] OFS_RST  = 16'h0000;
  // ==================================================================
  // saturation limits and offset-binary flip
  localparam logic signed [16:0] FS_NEG   = 17'h1f800;
  localparam logic signed [16:0] FS_POS   = 17'h007ff;
  localparam logic [11:0]        MID_FLIP = 12'h800;
  localparam logic [11:0]        ALL_ONE  = 12'hfff;
  localparam logic [11:0]        ALL_ZERO = 12'h000;
  // ==================================================================
  // pin vector positions
  localparam int PIN_XCTL   = 0;
  localparam int PIN_IL     = 1;
  localparam int PIN_ONE    = 2;
  localparam int PIN_PH     = 3;
  localparam int PIN_PAT    = 4;
  localparam int PIN_DOWN_I = 5;
  localparam int PIN_DOWN_Q = 6;
  localparam int PIN_LNK    = 7;
  localparam int PIN_N      = 8;
  localparam logic [7:0] PIN_RST = 8'h01;  // filters start in pin control, link low
  // ==================================================================
  // timing: default half sample period before the first measurement
  localparam int LINK_PERIOD_NS = 125;
  localparam int CLK_PERIOD_NS  = 10;
  localparam logic [7:0] LINK_HALF_CYC = 8'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  // ==================================================================
  // carriers
  typedef struct packed {
    logic [11:0] bus_a;  // first bus of the channel
    logic [11:0] bus_b;  // second bus, used in demux setting
    logic        over;   // out-of-range flag
    logic        dclk;   // output data clock
    logic        oe;     // bus drive enable, low means high impedance
  } amsom_chan_t;
  typedef struct packed {
    logic il;      // interleaved sampling
    logic qsel;    // interleave takes the q input
    logic both;    // interleave takes both inputs
    logic single;  // one bus per channel
    logic ph90;    // data midway between clock edges
    logic pat;     // test pattern replaces data
    logic pd_i;    // i channel powered down
    logic pd_q;    // q channel powered down
  } amsom_cfg_t;
endpackage : amsom_pkg

/* bench/amsom_capture.sv */
// far-side capture model: takes one channel's buses at each data clock toggle while oe is high
// assumes the device's words settle no later than the toggle, seen on clk_sys
`timescale 1ns/1ps
module amsom_capture (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // channel from the device
  input  wire amsom_pkg::amsom_chan_t chan,
  // captured unit
  output logic                        cap_vld,
  output amsom_pkg::amsom_chan_t      cap,
  output logic [3:0]                  cap_lag
);
  // ==========
  // state
  logic        dclk_reg;  // data clock seen last cycle
  logic [24:0] data_reg;  // buses and flag seen last cycle
  logic [3:0]  age_reg;   // cycles since the data last moved
  wire  [24:0] data_now = {chan.bus_a, chan.bus_b, chan.over};
  wire         moved    = data_now != data_reg;
  // ==========
  // a toggle hands over a unit; the lag shows where data moved against it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dclk_reg <= 1'b0;
      data_reg <= '0;
      age_reg  <= '0;
      cap_vld  <= 1'b0;
      cap      <= '0;
      cap_lag  <= '0;
    end else begin
      dclk_reg <= chan.dclk;
      data_reg <= data_now;
      age_reg  <= moved ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
      // undriven buses carry nothing, so a powered-down channel is not taken
      cap_vld  <= chan.oe && (chan.dclk != dclk_reg);
      cap      <= chan;
      cap_lag  <= moved ? 4'h0 : age_reg + 4'h1;
    end
  end
endmodule : amsom_capture

/* bench/adc_mode_select_output_mux_test.sv */
// self-checking bench for the converter mode select and output mux
// assumes amsom_pkg, amsom_top and amsom_capture are compiled first
`timescale 1ns/1ps
module adc_mode_select_output_mux_test;
  // ==========
  // ports and bench state
  logic                   clk_sys, rst_b, sample_clk, psel, penable, pwrite, last_err, sc_d;
  logic [6:0]             pv;  // control pins by package position
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   pready, pslverr, vld_i, vld_q;
  logic signed [13:0]     core_i, core_q;
  logic [3:0]             lag_i, lag_q;
  amsom_pkg::amsom_chan_t chan_i_out, chan_q_out, cap_i, cap_q;
  int                     fails, checked, cyc, cnt_i, tix, o_i, o_q;
  int                     g_i = 16384, g_q = 16384;
  int                     exp_i[$], exp_q[$];  // {flag, word} of recent samples
  bit                     mon_on, il_mode, src_i, src_q, sat_mode, pat_mode, ph_chk, ph_exp;
  int                     sat_tbl[7] = '{-2049, -2048, 2047, 2048, -8192, 8191, 0};
  // ==========
  // design and far-side models
  amsom_top u_dut (
    .clk_sys, .rst_b, .sample_clk, .core_i, .core_q,
    .extended_ctrl_enable_n   (pv[amsom_pkg::PIN_XCTL]),
    .interleave_pin           (pv[amsom_pkg::PIN_IL]),
    .single_bus_select        (pv[amsom_pkg::PIN_ONE]),
    .double_rate_phase_select (pv[amsom_pkg::PIN_PH]),
    .pattern_output_select    (pv[amsom_pkg::PIN_PAT]),
    .powerdown_i_chan         (pv[amsom_pkg::PIN_DOWN_I]),
    .powerdown_q_chan         (pv[amsom_pkg::PIN_DOWN_Q]),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .chan_i_out, .chan_q_out);
  amsom_capture u_cap_i (.clk_sys, .rst_b, .chan(chan_i_out), .cap_vld(vld_i), .cap(cap_i), .cap_lag(lag_i));
  amsom_capture u_cap_q (.clk_sys, .rst_b, .chan(chan_q_out), .cap_vld(vld_q), .cap(cap_q), .cap_lag(lag_q));
  // ==========
  // clocks; the sample clock is offset so its edges never meet clk_sys edges
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    sample_clk = 1'b0;
    #3;
    forever #62.5 sample_clk = ~sample_clk;
  end
  // ==========
  // reference model of one converter word
  function automatic int model(int raw, int g, int o);
    int v;
    v = (raw * g) >>> 14;
    v = (o & 4096) ? v - (o & 4095) : v + (o & 4095);
    if (v < -2048) return 32'h1000;
    if (v > 2047) return 32'h1fff;
    return v + 2048;
  endfunction : model
  // next core value: boundary table or random in range
  function automatic int nxt();
    if (sat_mode) begin
      tix++;
      return sat_tbl[tix % 7];
    end
    return int'($urandom_range(4095)) - 2048;
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // compare one captured unit with the newest expected samples
  task automatic cmp(input string nm, input amsom_pkg::amsom_chan_t c, input logic [3:0] lag, ref int q[$]);
    int n;
    n = q.size();
    if (pat_mode) begin
      chk({nm, " pattern step"}, 32'(c.bus_b), 32'(c.bus_a + 12'h001));
      chk({nm, " pattern flag"}, 32'(c.over), 32'(c.bus_b[0]));
    end else if (pv[amsom_pkg::PIN_ONE]) begin
      chk({nm, " word"}, 32'(c.bus_a), q[n-1] & 4095);
      chk({nm, " flag"}, 32'(c.over), q[n-1] >> 12);
    end else begin
      chk({nm, " first"}, 32'(c.bus_a), q[n-2] & 4095);
      chk({nm, " second"}, 32'(c.bus_b), q[n-1] & 4095);
      chk({nm, " flag"}, 32'(c.over), q[n-1] >> 12);
    end
    if (ph_chk) chk({nm, " phase"}, 32'(lag != 0), 32'(ph_exp));
  endtask : cmp
  // ==========
  // fresh core values at every sample edge; expectations follow the mode
  always @(posedge clk_sys) begin : smp
    int vi, vq;
    sc_d <= sample_clk;
    if (sample_clk !== sc_d) begin
      vi = nxt();
      vq = nxt();
      core_i <= 14'(vi);
      core_q <= 14'(vq);
      if (sample_clk) exp_i.push_back(model(src_i ? vq : vi, g_i, o_i));
      if (sample_clk != il_mode) exp_q.push_back(model(src_q ? vq : vi, g_q, o_q));
      if (exp_i.size() > 4) void'(exp_i.pop_front());
      if (exp_q.size() > 4) void'(exp_q.pop_front());
    end
  end
  // captured units are checked only while a run is open
  always @(posedge clk_sys) begin
    if (mon_on && vld_i) begin
      cmp("chan i", cap_i, lag_i, exp_i);
      cnt_i++;
    end
    if (mon_on && vld_q) cmp("chan q", cap_q, lag_q, exp_q);
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end
  // ==========
  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask : wr
  task automatic rr(input logic [3:0] i, input logic [31:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
    chk($sformatf("reg %0d", i), rd, e);
  endtask : rr
  // pins change, then the input filters settle
  task automatic setp(input logic [6:0] v);
    @(posedge clk_sys);
    pv <= v;
    repeat (10) @(posedge clk_sys);
  endtask : setp
  // settle three sample periods, then watch n periods and the unit rate
  task automatic run(input int n);
    int e;
    e = pv[amsom_pkg::PIN_ONE] ? n : n / 2;
    repeat (3) @(posedge sample_clk);
    cnt_i = 0;
    mon_on = 1;
    repeat (n) @(posedge sample_clk);
    mon_on = 0;
    chk("unit rate", 32'(cnt_i >= e - 1 && cnt_i <= e + 1), 1);
  endtask : run
  task automatic final_report;
    $display("checks %0d errors %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // ==========
  // main sequence
  initial begin
    pv = 7'h05;
    {psel, penable, pwrite, paddr, pwdata, core_i, core_q, rst_b} = '0;
    src_q = 1;
    void'($urandom(32'h73ec));
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk_sys);
    run(12);
    setp(7'h01);
    run(12);
    sat_mode = 1;
    setp(7'h05);
    run(14);
    sat_mode = 0;
    il_mode = 1;
    src_q = 0;
    setp(7'h07);
    run(12);
    setp(7'h03);
    run(12);
    il_mode = 0;
    src_q = 1;
    ph_chk = 1;
    ph_exp = 1;
    setp(7'h0d);
    run(8);
    ph_exp = 0;
    setp(7'h05);
    run(8);
    ph_chk = 0;
    pat_mode = 1;
    setp(7'h11);
    run(12);
    pat_mode = 0;
    setp(7'h65);
    chk("oe i", 32'(chan_i_out.oe), 0);
    chk("oe q", 32'(chan_q_out.oe), 0);
    // serial control with the interleave pin left high
    setp(7'h06);
    rr(amsom_pkg::REG_CFG, 32'h0);
    rr(amsom_pkg::REG_GAIN_I, 32'h4000);
    run(8);
    wr(amsom_pkg::REG_CFG, 32'h80);
    il_mode = 1;
    src_q = 0;
    run(10);
    wr(amsom_pkg::REG_CFG, 32'hc0);
    src_i = 1;
    src_q = 1;
    run(10);
    apb(1'b0, 8'h3c, 32'h0);
    chk("status", rd & 32'hff, 32'hd0);
    wr(amsom_pkg::REG_CFG, 32'ha0);
    src_i = 0;
    setp(7'h02);
    run(12);
    wr(amsom_pkg::REG_CFG, 32'h0);
    il_mode = 0;
    setp(7'h06);
    wr(amsom_pkg::REG_GAIN_I, 32'h2000);
    wr(amsom_pkg::REG_OFS_I, 32'h1005);
    wr(amsom_pkg::REG_GAIN_Q, 32'h3000);
    wr(amsom_pkg::REG_OFS_Q, 32'h0007);
    {g_i, o_i, g_q, o_q} = {32'd8192, 32'h1005, 32'd12288, 32'd7};
    run(10);
    // serial phase bit takes over from the pin
    wr(amsom_pkg::REG_CFG, 32'h4000);
    {ph_chk, ph_exp} = 2'b11;
    run(6);
    {ph_chk, ph_exp} = 2'b00;
    wr(4'h5, 32'hdeadbeef);
    rr(4'h5, 32'h0000beef);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'(last_err), 1);
    wr(amsom_pkg::REG_CFG, 32'hc00);
    repeat (4) @(posedge clk_sys);
    chk("oe q cfg", 32'(chan_q_out.oe), 0);
    chk("oe i cfg", 32'(chan_i_out.oe), 0);
    setp(7'h05);
    wr(amsom_pkg::REG_GAIN_I, 32'h1234);
    chk("oe q pins", 32'(chan_q_out.oe), 1);
    setp(7'h04);
    rr(amsom_pkg::REG_GAIN_I, 32'h4000);
    rr(amsom_pkg::REG_CFG, 32'h0);
    final_report;
  end
endmodule : adc_mode_select_output_mux_test
